// [src/dlic_map.svh]
`ifndef DLIC_MAP_SVH
`define DLIC_MAP_SVH

// byte offsets of the register window
`define DLIC_NORMAL_MASKED_OFF   12'h180
`define DLIC_NORMAL_UNMASKED_OFF 12'h184
`define DLIC_NORMAL_MASK_OFF     12'h188
`define DLIC_NORMAL_CLEAR_OFF    12'h18C
`define DLIC_NORMAL_SOFT_OFF     12'h190
`define DLIC_FAST_MASKED_OFF     12'h280
`define DLIC_FAST_UNMASKED_OFF   12'h284
`define DLIC_FAST_MASK_OFF       12'h288
`define DLIC_FAST_CLEAR_OFF      12'h28C
`define DLIC_FAST_SOFT_OFF       12'h290

// field positions and reset values
`define DLIC_SOFT_BIT            1
`define DLIC_MASK_RESET          32'h0000_0000
`define DLIC_SOFT_RESET          1'b0
`define DLIC_ZERO_WORD           32'h0000_0000
`define DLIC_UNUSED_SOURCES      32'h0430_0001

`endif

// [src/dlic_pkg.sv]
package dlic_pkg;
  typedef logic [31:0] dlic_word_t;

  // which register an apb address selects
  typedef enum logic [3:0] {
    DLIC_SEL_NONE,
    DLIC_SEL_N_MASKED,
    DLIC_SEL_N_UNMASKED,
    DLIC_SEL_N_MASK,
    DLIC_SEL_N_CLEAR,
    DLIC_SEL_N_SOFT,
    DLIC_SEL_F_MASKED,
    DLIC_SEL_F_UNMASKED,
    DLIC_SEL_F_MASK,
    DLIC_SEL_F_CLEAR,
    DLIC_SEL_F_SOFT
  } dlic_sel_t;

  // state of one request line
  typedef struct packed {
    dlic_word_t mask;
    logic       intr_n;
  } dlic_line_state_t;

  // state of the top block
  typedef struct packed {
    dlic_word_t src_sync1;
    dlic_word_t src_sync2;
    logic       soft_bit;
    dlic_word_t prdata;
  } dlic_top_state_t;
endpackage

// [src/dlic_line.sv]
`timescale 1ns/1ps
`include "dlic_map.svh"

// one request line: enable mask with set/clear ports, masked status, output
module dlic_line (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              set_we,
  input  wire logic              clear_we,
  input  wire dlic_pkg::dlic_word_t wdata,
  input  wire dlic_pkg::dlic_word_t unmasked,
  output dlic_pkg::dlic_word_t   mask,
  output dlic_pkg::dlic_word_t   masked,
  output logic                   intr_n
);
  dlic_pkg::dlic_line_state_t st;
  dlic_pkg::dlic_line_state_t next_st;

  // mask changes only through set and clear ports; both in one write cannot occur
  always_comb begin
    next_st = st;
    if (set_we) begin
      next_st.mask = st.mask | wdata;
    end
    if (clear_we) begin
      next_st.mask = st.mask & ~wdata;
    end
    next_st.intr_n = ~|(unmasked & next_st.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.mask   <= `DLIC_MASK_RESET;
      st.intr_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign mask   = st.mask;
  assign masked = unmasked & st.mask;
  assign intr_n = st.intr_n;
endmodule

// [src/dlic_top.sv]
// Behaviour
// - each line's masked status is unmasked status ANDed with its enable mask.
// - active-low request is registered: low while any masked status bit is one, but source changes reach it one clock after the status.
// - unmasked status reads identically at normal and fast addresses.
// - unmasked bit reads one while its source is asserting; pin sources arrive two clocks late through the sync flops.
// - enable masks are readable, changed only by set and clear ports.
// - mask one passes a source, zero blocks it; masks reset to zero.
// - set port write sets mask bits whose data bit is one.
// - clear port write clears mask bits whose data bit is one.
// - set port shares the mask offset; reads give mask, writes set.
// - software port write loads data bit 1 into unmasked bit 1.
// - status read-only; mask offset reads mask and takes set writes; clear, soft ports write-only.
// - no priority; any enabled source drives either line or both.
// - sources are level-sensitive; status follows the source level.
// - unused source positions read zero; software writes zero there.
`timescale 1ns/1ps
`include "dlic_map.svh"

module dlic_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] src_in,
  output logic             normal_intr_out_n,
  output logic             fast_intr_out_n,
  output logic             intr_out
);
  dlic_pkg::dlic_top_state_t st;
  dlic_pkg::dlic_top_state_t next_st;
  dlic_pkg::dlic_sel_t       sel;
  dlic_pkg::dlic_word_t      unmasked_pending;
  dlic_pkg::dlic_word_t      normal_mask_read;
  dlic_pkg::dlic_word_t      fast_mask_read;
  dlic_pkg::dlic_word_t      normal_masked_pending;
  dlic_pkg::dlic_word_t      fast_masked_pending;
  logic                      wr_acc;
  logic                      rd_acc;

  // zero-wait slave: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & ~penable & ~pwrite;

  // address decode; the set port shares the mask offset
  always_comb begin
    case (paddr)
      `DLIC_NORMAL_MASKED_OFF:   sel = dlic_pkg::DLIC_SEL_N_MASKED;
      `DLIC_NORMAL_UNMASKED_OFF: sel = dlic_pkg::DLIC_SEL_N_UNMASKED;
      `DLIC_NORMAL_MASK_OFF:     sel = dlic_pkg::DLIC_SEL_N_MASK;
      `DLIC_NORMAL_CLEAR_OFF:    sel = dlic_pkg::DLIC_SEL_N_CLEAR;
      `DLIC_NORMAL_SOFT_OFF:     sel = dlic_pkg::DLIC_SEL_N_SOFT;
      `DLIC_FAST_MASKED_OFF:     sel = dlic_pkg::DLIC_SEL_F_MASKED;
      `DLIC_FAST_UNMASKED_OFF:   sel = dlic_pkg::DLIC_SEL_F_UNMASKED;
      `DLIC_FAST_MASK_OFF:       sel = dlic_pkg::DLIC_SEL_F_MASK;
      `DLIC_FAST_CLEAR_OFF:      sel = dlic_pkg::DLIC_SEL_F_CLEAR;
      `DLIC_FAST_SOFT_OFF:       sel = dlic_pkg::DLIC_SEL_F_SOFT;
      default:                   sel = dlic_pkg::DLIC_SEL_NONE;
    endcase
  end

  // unmapped addresses and wrong-direction accesses get an error answer
  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      case (sel)
        dlic_pkg::DLIC_SEL_NONE: pslverr = 1'b1;
        dlic_pkg::DLIC_SEL_N_MASKED, dlic_pkg::DLIC_SEL_N_UNMASKED,
        dlic_pkg::DLIC_SEL_F_MASKED, dlic_pkg::DLIC_SEL_F_UNMASKED: pslverr = pwrite;
        dlic_pkg::DLIC_SEL_N_CLEAR, dlic_pkg::DLIC_SEL_N_SOFT,
        dlic_pkg::DLIC_SEL_F_CLEAR, dlic_pkg::DLIC_SEL_F_SOFT: pslverr = ~pwrite;
        default: pslverr = 1'b0;
      endcase
    end
  end

  // pins pass two plain flops; no logic between them, so the first may settle
  always_comb begin
    next_st           = st;
    next_st.src_sync1 = src_in;
    next_st.src_sync2 = st.src_sync1;
    if (wr_acc && (sel == dlic_pkg::DLIC_SEL_N_SOFT || sel == dlic_pkg::DLIC_SEL_F_SOFT)) begin
      next_st.soft_bit = pwdata[`DLIC_SOFT_BIT];
    end
    // read data captured in setup so it is stable through the access cycle
    if (rd_acc) begin
      case (sel)
        dlic_pkg::DLIC_SEL_N_MASKED:   next_st.prdata = normal_masked_pending;
        dlic_pkg::DLIC_SEL_F_MASKED:   next_st.prdata = fast_masked_pending;
        dlic_pkg::DLIC_SEL_N_UNMASKED,
        dlic_pkg::DLIC_SEL_F_UNMASKED: next_st.prdata = unmasked_pending;
        dlic_pkg::DLIC_SEL_N_MASK:     next_st.prdata = normal_mask_read;
        dlic_pkg::DLIC_SEL_F_MASK:     next_st.prdata = fast_mask_read;
        default:                       next_st.prdata = `DLIC_ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.src_sync1 <= `DLIC_ZERO_WORD;
      st.src_sync2 <= `DLIC_ZERO_WORD;
      st.soft_bit  <= `DLIC_SOFT_RESET;
      st.prdata    <= `DLIC_ZERO_WORD;
    end else begin
      st <= next_st;
    end
  end

  // one common status word feeds both lines with equal weight
  always_comb begin
    unmasked_pending                 = st.src_sync2 & ~`DLIC_UNUSED_SOURCES;
    unmasked_pending[`DLIC_SOFT_BIT] = st.soft_bit;
  end

  assign prdata = st.prdata;

  dlic_line u_normal (
    .pclk     (pclk),
    .presetn  (presetn),
    .set_we   (wr_acc && sel == dlic_pkg::DLIC_SEL_N_MASK),
    .clear_we (wr_acc && sel == dlic_pkg::DLIC_SEL_N_CLEAR),
    .wdata    (pwdata),
    .unmasked (unmasked_pending),
    .mask     (normal_mask_read),
    .masked   (normal_masked_pending),
    .intr_n   (normal_intr_out_n)
  );

  dlic_line u_fast (
    .pclk     (pclk),
    .presetn  (presetn),
    .set_we   (wr_acc && sel == dlic_pkg::DLIC_SEL_F_MASK),
    .clear_we (wr_acc && sel == dlic_pkg::DLIC_SEL_F_CLEAR),
    .wdata    (pwdata),
    .unmasked (unmasked_pending),
    .mask     (fast_mask_read),
    .masked   (fast_masked_pending),
    .intr_n   (fast_intr_out_n)
  );

  // combined active-high request for a system-level interrupt collector
  assign intr_out = ~normal_intr_out_n | ~fast_intr_out_n;
endmodule

// [tb/dlic_assertions.sv]
`timescale 1ns/1ps
// watches the apb port and the request pins of the controller
module dlic_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        normal_intr_out_n,
  input wire logic        fast_intr_out_n,
  input wire logic        intr_out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // access phase of any transfer
  wire logic acc = psel && penable;
  a_intr_or: assert property (intr_out == (!normal_intr_out_n || !fast_intr_out_n))
    else $error("combined request wrong");
  a_reset_quiet: assert property ($rose(presetn) |->
    normal_intr_out_n && fast_intr_out_n)
    else $error("request active after reset");
  a_unmapped_err: assert property (acc && paddr[11:8] == 4'h3 |-> pslverr)
    else $error("unmapped access not refused");
  a_ro_write_err: assert property (acc && pwrite && paddr[7:0] == 8'h84 |-> pslverr)
    else $error("write to status not refused");
  a_wo_read_err: assert property (
    acc && !pwrite && paddr[7:0] inside {8'h8C, 8'h90} |-> pslverr)
    else $error("read of write port not refused");
  a_set_no_err: assert property (acc && pwrite && paddr == 12'h188 |-> !pslverr)
    else $error("set port write refused");
  a_mask_read_ok: assert property (acc && !pwrite && paddr == 12'h288 |-> !pslverr)
    else $error("mask read refused");
  a_reserved_zero: assert property (
    acc && !pwrite && paddr == 12'h184 |-> (prdata & 32'h0430_0001) == 32'h0)
    else $error("reserved source bit set");
  a_err_zero: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
endmodule
bind dlic_top dlic_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
  .normal_intr_out_n(normal_intr_out_n), .fast_intr_out_n(fast_intr_out_n), .intr_out(intr_out));

// [tb/dlic_host_model.sv]
`timescale 1ns/1ps
// host core: records which request lines have asked for service
module dlic_host_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       normal_intr_out_n,
  input  wire logic       fast_intr_out_n,
  output logic      [1:0] taken
);
  // both lines taken at equal weight, so neither can hide the other
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) taken <= 2'b00;
    else taken <= taken | {~fast_intr_out_n, ~normal_intr_out_n};
  end
endmodule

// [tb/dual_line_interrupt_controller_tb_top.sv]
`timescale 1ns/1ps
module dual_line_interrupt_controller_tb_top;
  typedef struct {logic [31:0] src, nm, fm, raw;} dlic_row_t;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, src_in = 32'h0000_0000, prdata, q;
  logic        pready, pslverr, nrm_n, fst_n, intr_out, e;
  logic [1:0]  taken;
  int          fail_count = 0, checked = 0, cyc = 0;
  logic [11:0] bad [5] = '{12'h18C, 12'h190, 12'h28C, 12'h290, 12'h3FC};
  // sources, normal mask, fast mask, expected unmasked status
  dlic_row_t   rows [4] = '{
    '{32'h0000_0010, 32'h0000_0010, 32'h0000_0000, 32'h0000_0010},
    '{32'hFFFF_FFFF, 32'h0000_0000, 32'hFBCF_FFFE, 32'hFBCF_FFFC},
    '{32'h8000_0004, 32'h8000_0000, 32'h0000_0004, 32'h8000_0004},
    '{32'h0430_0001, 32'hFBCF_FFFE, 32'hFBCF_FFFE, 32'h0000_0000}};
  dlic_top u_dlic_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_in(src_in), .normal_intr_out_n(nrm_n),
    .fast_intr_out_n(fst_n), .intr_out(intr_out));
  dlic_host_model u_dlic_host_model (.pclk(pclk), .presetn(presetn),
    .normal_intr_out_n(nrm_n), .fast_intr_out_n(fst_n), .taken(taken));
  initial forever #25 pclk = ~pclk;
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic final_report;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one apb transfer; waits on pready rather than assuming zero wait states
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] x, y);
    checked++;
    if (y !== x) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", n, x, y);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, x, q);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h188, 32'h0000_0000, "mask rst");
    chk("out rst", 32'h1, {31'h0, nrm_n});
    foreach (rows[i]) begin
      src_in <= rows[i].src;
      apb(1'b1, 12'h18C, 32'hFBCF_FFFE);
      apb(1'b1, 12'h28C, 32'hFBCF_FFFE);
      apb(1'b1, 12'h188, rows[i].nm);
      apb(1'b1, 12'h288, rows[i].fm);
      repeat (3) @(posedge pclk);
      rd(12'h184, rows[i].raw, "raw n");
      rd(12'h284, rows[i].raw, "raw f");
      rd(12'h180, rows[i].raw & rows[i].nm, "masked n");
      rd(12'h280, rows[i].raw & rows[i].fm, "masked f");
      rd(12'h288, rows[i].fm, "mask f");
      chk("out n", {31'h0, |(rows[i].raw & rows[i].nm)}, {31'h0, ~nrm_n});
      chk("out f", {31'h0, |(rows[i].raw & rows[i].fm)}, {31'h0, ~fst_n});
      chk("out c", 32'(|(rows[i].raw & (rows[i].nm | rows[i].fm))), 32'(intr_out));
    end
    // partial set then partial clear, and a write to a read-only place
    apb(1'b1, 12'h18C, 32'hFBCF_FFFE);
    apb(1'b1, 12'h188, 32'h0000_0030);
    apb(1'b1, 12'h18C, 32'h0000_0010);
    apb(1'b1, 12'h184, 32'h0000_0030);
    chk("ro err", 32'h1, {31'h0, e});
    rd(12'h188, 32'h0000_0020, "set clr");
    foreach (bad[i]) begin
      rd(bad[i], 32'h0000_0000, "wo read");
      chk("wo err", 32'h1, {31'h0, e});
    end
    // software source raises bit 1, read at the normal view, then drops it, read at the fast view
    src_in <= 32'h0000_0000;
    apb(1'b1, 12'h290, 32'h0000_0002);
    apb(1'b1, 12'h188, 32'h0000_0002);
    rd(12'h188, 32'h0000_0022, "set keep");
    rd(12'h184, 32'h0000_0002, "soft n");
    chk("soft out", 32'h0, {31'h0, nrm_n});
    apb(1'b1, 12'h190, 32'h0000_0000);
    rd(12'h284, 32'h0000_0000, "soft off");
    // only data bit 1 reaches the soft source; the other bits are ignored
    apb(1'b1, 12'h190, 32'hFBCF_FFFC);
    rd(12'h184, 32'h0000_0000, "soft ign");
    chk("host", 32'h3, {30'h0, taken});
    // reset in mid-run with a mask and the soft source active
    apb(1'b1, 12'h290, 32'h0000_0002);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h188, 32'h0000_0000, "mask rst2");
    rd(12'h184, 32'h0000_0000, "soft rst");
    chk("out rst2", 32'h1, {31'h0, nrm_n});
    final_report();
  end
endmodule
